//--- rtl/afd_defines.svh
// Purpose: named numbers of the addressing field decoder
// Assumes: 32-bit APB data, byte addresses on paddr[7:0]
// Notes: definitions only
`ifndef AFD_DEFINES_SVH
`define AFD_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define AFD_OFS_BYTES 8'h00
`define AFD_OFS_CTL 8'h04
`define AFD_OFS_FLAGS 8'h08
`define AFD_OFS_IMM 8'h0c
`define AFD_OFS_EA 8'h10
`define AFD_OFS_OPND 8'h14
`define AFD_OFS_IMMX 8'h18

// ==========================================================================
// reset values
`define AFD_BYTES_RST 32'h0000_0000
`define AFD_CTL_RST 32'h0000_0300
`define AFD_FLAGS_RST 32'h0000_0000
`define AFD_IMM_RST 32'h0000_0000

// ==========================================================================
// address-byte register fields
`define AFD_MODRM_MSB 7
`define AFD_MODRM_LSB 0
`define AFD_SIB_MSB 15
`define AFD_SIB_LSB 8

// ==========================================================================
// control register fields
`define AFD_CTL_DEF32 0
`define AFD_CTL_APFX 1
`define AFD_CTL_W 2
`define AFD_CTL_D 3
`define AFD_CTL_S 4
`define AFD_CTL_IMM8 5
`define AFD_CTL_IMPL 6
`define AFD_CTL_CLS_MSB 9
`define AFD_CTL_CLS_LSB 8
`define AFD_CTL_EEE_MSB 14
`define AFD_CTL_EEE_LSB 12
`define AFD_CTL_SEG_MSB 18
`define AFD_CTL_SEG_LSB 16
`define AFD_CTL_TTTN_MSB 23
`define AFD_CTL_TTTN_LSB 20

// ==========================================================================
// flag register fields
`define AFD_FLG_OF 0
`define AFD_FLG_CF 1
`define AFD_FLG_ZF 2
`define AFD_FLG_SF 3
`define AFD_FLG_PF 4

// ==========================================================================
// mode, rm, index and register codes
`define AFD_MOD_NODISP 2'h0
`define AFD_MOD_DISP8 2'h1
`define AFD_MOD_DISPW 2'h2
`define AFD_MOD_REG 2'h3
`define AFD_RM_SIB 3'h4
`define AFD_RM_D32 3'h5
`define AFD_RM_D16 3'h6
`define AFD_IDX_NONE 3'h4
`define AFD_GPR_BASE 3'h3
`define AFD_GPR_STACK 3'h4
`define AFD_GPR_FRAME 3'h5
`define AFD_GPR_SRCIDX 3'h6
`define AFD_GPR_DSTIDX 3'h7
`define AFD_SEG_LAST 3'h5
`define AFD_BYTE_HI_CODE 3'h4

`endif

//--- rtl/afd_pkg.sv
// Purpose: types shared by the addressing field decoder and its users
// Assumes: afd_defines.svh supplies every number
// Notes: structs are packed so they read back over the bus
package afd_pkg;

   // =======================================================================
   // enumerations
   typedef enum logic [1:0] {AFD_DISP_NONE, AFD_DISP_8, AFD_DISP_16, AFD_DISP_32} afd_disp_e;
   typedef enum logic [1:0] {AFD_CLS_CTRL, AFD_CLS_DEBUG, AFD_CLS_TEST, AFD_CLS_NONE} afd_cls_e;

   // =======================================================================
   // effective-address decode
   typedef struct packed {
      logic addr32;
      logic implied;
      logic sib_present;
      logic reg_operand;
      logic has_base;
      logic [2:0] base_reg;
      logic has_index;
      logic [2:0] index_reg;
      logic [1:0] scale;
      afd_disp_e disp_size;
      logic stack_seg;
      logic [1:0] disp_offset;
   } afd_ea_s;

   // =======================================================================
   // register operands, condition and special selects
   typedef struct packed {
      logic [2:0] rm_num;
      logic rm_high;
      logic [2:0] reg_num;
      logic reg_high;
      logic [2:0] op_ext;
      logic reg_is_dest;
      logic cond_true;
      logic [2:0] seg_num;
      logic seg_valid;
      logic [2:0] spec_num;
      logic spec_valid;
      logic undefined;
   } afd_opnd_s;

endpackage

//--- rtl/afd_decoder.sv
// Purpose: addressing field decoder with an APB register face
// Assumes: one clock pclk at 20 MHz, presetn asynchronous active low
// Notes: decode is combinational from the registers and captured each cycle
//
// Summary of operation
// RL1: implied modes skip addressing; others use the mode/rm byte.
// RL2: 32-bit addressing expects scaled-index byte at rm 100, mode not 11.
// RL3: scaled-index address uses mode, scale, index and base.
// RL4: middle mode/rm bits serve as opcode extension and register select.
// RL5: mode/rm uses the 16-bit or 32-bit map per address size.
// RL6: 16-bit rm picks base/index pairs; frame forms use stack; d8 or d16.
// RL7: 16-bit mode 00 rm 110 is bare d16 in data segment.
// RL8: mode 11 selects a register; byte codes give low then high bytes.
// RL9: 32-bit rm is a base; mode 00 rm 101 is bare d32; frame uses stack.
// RL10: scaled-index address is base plus scaled index plus none, d8 or d32.
// RL11: scaled-index base 101 under mode 00 means d32 plus index, no base.
// RL12: scaled-index base stack or frame pointer selects stack segment.
// RL13: scale codes 00 to 11 multiply the index by 1, 2, 4, 8.
// RL14: index 100 means no index; others select that register.
// RL15: encoders keep scale 00 when index is 100, else address undefined.
// RL16: direction bit 0 makes reg the source, 1 the destination.
// RL17: sign-extend bit widens only an 8-bit immediate to full size.
// RL18: lowest condition bit negates the condition when set.
// RL19: upper condition bits: overflow, below, zero, below-equal, sign, parity, less, less-equal.
// RL20: control codes 000, 010, 011 valid; others undefined.
// RL21: debug codes 000 to 011, 110, 111 valid; others undefined.
// RL22: test codes 110 and 111 valid; others undefined.
// RL23: segment select 000 to 101 maps six segments; 110 and 111 reserved.
// RL24: address size is segment default, toggled by the size prefix.
// RL25: operand-size bit picks byte when 0, full size when 1.
// RL26: displacement follows mode/rm byte or scaled-index byte.
// RL27: conditions use carry, carry-or-zero, sign xor overflow, plus zero.
// RL28: reserved segment or unlisted special codes raise an undefined flag.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "afd_defines.svh"

module afd_decoder
   import afd_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output afd_ea_s ea_o,
   output afd_opnd_s opnd_o,
   output logic [31:0] imm_ext_o
);

   // =======================================================================
   // helpers
   // byte operands: codes 0..3 are low bytes, 4..7 the high bytes of 0..3
   function automatic logic [3:0] gpr_sel(input logic [2:0] code, input logic w);
      if (!w && code >= `AFD_BYTE_HI_CODE)
         gpr_sel = {1'b1, code - `AFD_BYTE_HI_CODE};
      else
         gpr_sel = {1'b0, code};
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `AFD_OFS_BYTES) || (a == `AFD_OFS_CTL) || (a == `AFD_OFS_FLAGS) ||
                  (a == `AFD_OFS_IMM) || (a == `AFD_OFS_EA) || (a == `AFD_OFS_OPND) ||
                  (a == `AFD_OFS_IMMX);
   endfunction

   // =======================================================================
   // registers
   logic [31:0] bytes_q;
   logic [31:0] ctl_q;
   logic [31:0] flags_q;
   logic [31:0] imm_q;
   afd_ea_s ea_q;
   afd_ea_s ea_d;
   afd_opnd_s opnd_q;
   afd_opnd_s opnd_d;
   logic [31:0] immx_q;
   logic [31:0] immx_d;
   logic [31:0] prdata_q;
   logic [31:0] rd_d;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] addr8;
   logic wr_en;

   assign addr8 = paddr[7:0];
   assign wr_en = psel && penable && pready_q && pwrite && is_mapped(addr8);

   // =======================================================================
   // apb handshake: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !is_mapped(addr8);
         prdata_q <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   always_comb
   begin
      case (addr8)
         `AFD_OFS_BYTES: rd_d = bytes_q;
         `AFD_OFS_CTL: rd_d = ctl_q;
         `AFD_OFS_FLAGS: rd_d = flags_q;
         `AFD_OFS_IMM: rd_d = imm_q;
         `AFD_OFS_EA: rd_d = 32'(ea_q);
         `AFD_OFS_OPND: rd_d = 32'(opnd_q);
         `AFD_OFS_IMMX: rd_d = immx_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // =======================================================================
   // software-written registers; result registers ignore writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bytes_q <= `AFD_BYTES_RST;
         ctl_q <= `AFD_CTL_RST;
         flags_q <= `AFD_FLAGS_RST;
         imm_q <= `AFD_IMM_RST;
      end
      else if (wr_en)
      begin
         case (addr8)
            `AFD_OFS_BYTES: bytes_q <= pwdata;
            `AFD_OFS_CTL: ctl_q <= pwdata;
            `AFD_OFS_FLAGS: flags_q <= pwdata;
            `AFD_OFS_IMM: imm_q <= pwdata;
            default: ;
         endcase
      end
   end

   // =======================================================================
   // field extraction
   logic [1:0] mode;
   logic [2:0] midf;
   logic [2:0] rm;
   logic [1:0] ss;
   logic [2:0] idx;
   logic [2:0] base;
   logic w;
   logic [3:0] tttn;
   logic [2:0] eee;
   logic [2:0] seg;
   afd_cls_e cls;

   assign mode = bytes_q[`AFD_MODRM_MSB -: 2];
   assign midf = bytes_q[`AFD_MODRM_LSB + 3 +: 3];
   assign rm = bytes_q[`AFD_MODRM_LSB +: 3];
   assign ss = bytes_q[`AFD_SIB_MSB -: 2];
   assign idx = bytes_q[`AFD_SIB_LSB + 3 +: 3];
   assign base = bytes_q[`AFD_SIB_LSB +: 3];
   assign w = ctl_q[`AFD_CTL_W];
   assign tttn = ctl_q[`AFD_CTL_TTTN_MSB:`AFD_CTL_TTTN_LSB];
   assign eee = ctl_q[`AFD_CTL_EEE_MSB:`AFD_CTL_EEE_LSB];
   assign seg = ctl_q[`AFD_CTL_SEG_MSB:`AFD_CTL_SEG_LSB];
   assign cls = afd_cls_e'(ctl_q[`AFD_CTL_CLS_MSB:`AFD_CTL_CLS_LSB]);

   // =======================================================================
   // effective-address decode
   always_comb
   begin
      ea_d = '0;
      ea_d.addr32 = ctl_q[`AFD_CTL_DEF32] ^ ctl_q[`AFD_CTL_APFX]; // RL24
      ea_d.implied = ctl_q[`AFD_CTL_IMPL];
      ea_d.disp_size = AFD_DISP_NONE;
      if (ctl_q[`AFD_CTL_IMPL])
      begin
         // fixed-mode instructions carry no addressing byte
         ea_d.has_base = 1'b0; // RL1
      end
      else if (mode == `AFD_MOD_REG)
      begin
         ea_d.reg_operand = 1'b1; // RL8
      end
      else if (!ea_d.addr32) // RL5
      begin
         ea_d.disp_offset = 2'h1; // RL26
         ea_d.has_base = 1'b1;
         case (rm) // RL6
            3'h0: {ea_d.base_reg, ea_d.index_reg} = {`AFD_GPR_BASE, `AFD_GPR_SRCIDX};
            3'h1: {ea_d.base_reg, ea_d.index_reg} = {`AFD_GPR_BASE, `AFD_GPR_DSTIDX};
            3'h2: {ea_d.base_reg, ea_d.index_reg} = {`AFD_GPR_FRAME, `AFD_GPR_SRCIDX};
            3'h3: {ea_d.base_reg, ea_d.index_reg} = {`AFD_GPR_FRAME, `AFD_GPR_DSTIDX};
            3'h4: ea_d.base_reg = `AFD_GPR_SRCIDX;
            3'h5: ea_d.base_reg = `AFD_GPR_DSTIDX;
            3'h6: ea_d.base_reg = `AFD_GPR_FRAME;
            default: ea_d.base_reg = `AFD_GPR_BASE;
         endcase
         ea_d.has_index = (rm <= 3'h3); // RL6
         ea_d.stack_seg = (ea_d.base_reg == `AFD_GPR_FRAME); // RL6
         if (mode == `AFD_MOD_DISP8)
            ea_d.disp_size = AFD_DISP_8;
         else if (mode == `AFD_MOD_DISPW)
            ea_d.disp_size = AFD_DISP_16;
         else if (rm == `AFD_RM_D16)
         begin
            // bare word displacement replaces the frame form here
            ea_d.has_base = 1'b0; // RL7
            ea_d.stack_seg = 1'b0; // RL7
            ea_d.disp_size = AFD_DISP_16; // RL7
         end
      end
      else if (rm == `AFD_RM_SIB) // RL2
      begin
         ea_d.sib_present = 1'b1; // RL3
         ea_d.disp_offset = 2'h2; // RL26
         ea_d.scale = ss; // RL13
         ea_d.has_index = (idx != `AFD_IDX_NONE); // RL14
         ea_d.index_reg = idx; // RL14
         ea_d.base_reg = base;
         ea_d.has_base = !(mode == `AFD_MOD_NODISP && base == `AFD_RM_D32); // RL11
         ea_d.stack_seg = (base == `AFD_GPR_STACK) || // RL12
                          (base == `AFD_GPR_FRAME && ea_d.has_base); // RL12
         case (mode) // RL10
            `AFD_MOD_DISP8: ea_d.disp_size = AFD_DISP_8;
            `AFD_MOD_DISPW: ea_d.disp_size = AFD_DISP_32;
            default: ea_d.disp_size = ea_d.has_base ? AFD_DISP_NONE : AFD_DISP_32; // RL11
         endcase
      end
      else
      begin
         ea_d.disp_offset = 2'h1; // RL26
         ea_d.base_reg = rm; // RL9
         ea_d.has_base = !(mode == `AFD_MOD_NODISP && rm == `AFD_RM_D32); // RL9
         ea_d.stack_seg = (rm == `AFD_GPR_FRAME) && ea_d.has_base; // RL9
         case (mode)
            `AFD_MOD_DISP8: ea_d.disp_size = AFD_DISP_8;
            `AFD_MOD_DISPW: ea_d.disp_size = AFD_DISP_32;
            default: ea_d.disp_size = ea_d.has_base ? AFD_DISP_NONE : AFD_DISP_32; // RL9
         endcase
      end
   end

   // =======================================================================
   // operands, condition, segment and special selects
   logic cond_raw;

   always_comb
   begin
      opnd_d = '0;
      {opnd_d.rm_high, opnd_d.rm_num} = gpr_sel(rm, w); // RL8 RL25
      {opnd_d.reg_high, opnd_d.reg_num} = gpr_sel(midf, w); // RL4 RL25
      opnd_d.op_ext = midf; // RL4
      opnd_d.reg_is_dest = ctl_q[`AFD_CTL_D]; // RL16
      case (tttn[3:1]) // RL19 RL27
         3'h0: cond_raw = flags_q[`AFD_FLG_OF];
         3'h1: cond_raw = flags_q[`AFD_FLG_CF];
         3'h2: cond_raw = flags_q[`AFD_FLG_ZF];
         3'h3: cond_raw = flags_q[`AFD_FLG_CF] | flags_q[`AFD_FLG_ZF];
         3'h4: cond_raw = flags_q[`AFD_FLG_SF];
         3'h5: cond_raw = flags_q[`AFD_FLG_PF];
         3'h6: cond_raw = flags_q[`AFD_FLG_SF] ^ flags_q[`AFD_FLG_OF];
         default: cond_raw = (flags_q[`AFD_FLG_SF] ^ flags_q[`AFD_FLG_OF]) |
                             flags_q[`AFD_FLG_ZF];
      endcase
      opnd_d.cond_true = cond_raw ^ tttn[0]; // RL18
      opnd_d.seg_num = seg;
      opnd_d.seg_valid = (seg <= `AFD_SEG_LAST); // RL23
      opnd_d.spec_num = eee;
      case (cls)
         AFD_CLS_CTRL: opnd_d.spec_valid = (eee == 3'h0) || (eee == 3'h2) ||
                                           (eee == 3'h3); // RL20
         AFD_CLS_DEBUG: opnd_d.spec_valid = (eee <= 3'h3) || (eee >= 3'h6); // RL21
         AFD_CLS_TEST: opnd_d.spec_valid = (eee >= 3'h6); // RL22
         default: opnd_d.spec_valid = 1'b1;
      endcase
      opnd_d.undefined = !opnd_d.seg_valid || !opnd_d.spec_valid; // RL28
   end

   // =======================================================================
   // immediate widening; byte operands pass the low byte unchanged
   always_comb
   begin
      if (!w)
         immx_d = {24'h00_0000, imm_q[7:0]};
      else if (ctl_q[`AFD_CTL_S] && ctl_q[`AFD_CTL_IMM8])
         immx_d = {{24{imm_q[7]}}, imm_q[7:0]}; // RL17
      else
         immx_d = imm_q; // RL17
   end

   // =======================================================================
   // result capture: one cycle behind any register write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ea_q <= '0;
         opnd_q <= '0;
         immx_q <= 32'h0000_0000;
      end
      else
      begin
         ea_q <= ea_d;
         opnd_q <= opnd_d;
         immx_q <= immx_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ea_o = ea_q;
   assign opnd_o = opnd_q;
   assign imm_ext_o = immx_q;

endmodule // afd_decoder

//--- sim/afd_decoder_monitor.sv
// Purpose: port checker for the addressing field decoder
// Assumes: pclk rising edge, presetn asynchronous active low
// Notes: idle two edges after reset
`timescale 1ns/1ns

module afd_decoder_monitor
   import afd_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire afd_ea_s ea_o,
   input wire afd_opnd_s opnd_o,
   input wire logic [31:0] imm_ext_o
);
   // ====================
   // settle counter
   logic [1:0] live_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         live_q <= 2'h0;
      else if (live_q != 2'h2)
         live_q <= live_q + 2'h1;
   end

   // ====================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || live_q != 2'h2);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   AST_ONE_WAIT: assert property (s_setup |=> s_answer)
      else $error("pready not one pulse");
   AST_ERR_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero while idle");
   AST_DECODE_AFTER_WRITE: assert property (
      $changed(ea_o) || $changed(opnd_o) || $changed(imm_ext_o)
      |-> $past(psel && penable && pready && pwrite, 2))
      else $error("decode changed without a write");
   AST_SIB_A32: assert property (
      ea_o.sib_present |-> ea_o.addr32 && ea_o.disp_offset == 2'h2)
      else $error("scaled byte not 32-bit");
   AST_OPEXT: assert property (opnd_o.op_ext[1:0] == opnd_o.reg_num[1:0])
      else $error("op_ext differs from reg_num");
   AST_A16_DISP: assert property (!ea_o.addr32 |-> ea_o.disp_size != AFD_DISP_32)
      else $error("d32 in 16-bit mode");
   AST_A32_DISP: assert property (ea_o.addr32 |-> ea_o.disp_size != AFD_DISP_16)
      else $error("d16 in 32-bit mode");
   AST_REG_NODISP: assert property (ea_o.reg_operand |-> ea_o.disp_offset == 2'h0)
      else $error("register operand with disp");
   AST_NOBASE: assert property (
      ea_o.sib_present && !ea_o.has_base |-> ea_o.disp_size == AFD_DISP_32 && !ea_o.stack_seg)
      else $error("baseless scaled form");
   AST_SIB_STACK: assert property (
      ea_o.sib_present && ea_o.has_base
      |-> ea_o.stack_seg == (ea_o.base_reg == 3'h4 || ea_o.base_reg == 3'h5))
      else $error("scaled form segment wrong");
   AST_INDEX: assert property (ea_o.has_index && ea_o.addr32 |-> ea_o.index_reg != 3'h4)
      else $error("index 100 used");
   AST_SEG: assert property (opnd_o.seg_valid == (opnd_o.seg_num <= 3'h5))
      else $error("segment valid wrong");
   AST_UNDEF: assert property (
      opnd_o.undefined == (!opnd_o.seg_valid || !opnd_o.spec_valid))
      else $error("undefined flag wrong");
endmodule // afd_decoder_monitor

bind afd_decoder afd_decoder_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .ea_o(ea_o), .opnd_o(opnd_o),
   .imm_ext_o(imm_ext_o));

//--- sim/afd_apb_master.sv
// Purpose: bus master model that issues register transfers
// Assumes: zero or more wait states, pready sampled at rising edges
// Notes: released address and data show the inverse
`timescale 1ns/1ns

module afd_apb_master
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // ====================
   // one transfer; only the bench watchdog ends a wait
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule // afd_apb_master

//--- sim/afd_decoder_bench.sv
// Purpose: self-checking bench for the addressing field decoder
// Assumes: 20 MHz pclk, outputs settle one edge after a write
// Notes: expected values from local reference functions
`timescale 1ns/1ns
`include "afd_defines.svh"

module afd_decoder_bench
   import afd_pkg::*;
   ;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   afd_ea_s ea;
   afd_opnd_s o;
   logic [31:0] imm;
   int fail_count;
   int checks;

   afd_apb_master mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   afd_decoder #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ea_o(ea), .opnd_o(o), .imm_ext_o(imm));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ====================
   // reference models
   function automatic logic [31:0] mkc(input logic [3:0] tn, input logic [2:0] sg,
                                       input logic [2:0] ee, input logic [1:0] cl,
                                       input logic [6:0] lo);
      return {8'h00, tn, 1'b0, sg, 1'b0, ee, 2'h0, cl, 1'b0, lo};
   endfunction

   function automatic afd_ea_s ref_ea(input logic a32, input logic [15:0] b);
      afd_ea_s e;
      logic [1:0] md;
      logic [2:0] rm;
      logic [2:0] bs;
      e = '0;
      md = b[7:6];
      rm = b[2:0];
      bs = b[10:8];
      e.addr32 = a32;
      e.disp_offset = 2'h1;
      e.has_base = 1'b1;
      e.disp_size = md == 2'h1 ? AFD_DISP_8 : md == 2'h0 ? AFD_DISP_NONE :
                    a32 ? AFD_DISP_32 : AFD_DISP_16;
      if (!a32)
      begin
         e.base_reg = rm[2] ? (rm[1] ? (rm[0] ? 3'h3 : 3'h5) : {2'h3, rm[0]}) :
                      (rm[1] ? 3'h5 : 3'h3);
         e.has_index = !rm[2];
         e.index_reg = {2'h3, rm[0]};
         e.stack_seg = rm[2:1] == 2'h1 || (rm == 3'h6 && md != 2'h0);
         e.has_base = !(md == 2'h0 && rm == 3'h6);
         e.disp_size = e.has_base ? e.disp_size : AFD_DISP_16;
      end
      else if (rm != 3'h4)
      begin
         e.base_reg = rm;
         e.stack_seg = rm == 3'h5 && md != 2'h0;
         e.has_base = !(md == 2'h0 && rm == 3'h5);
         e.disp_size = e.has_base ? e.disp_size : AFD_DISP_32;
      end
      else
      begin
         e.sib_present = 1'b1;
         e.disp_offset = 2'h2;
         e.base_reg = bs;
         e.scale = b[15:14];
         e.index_reg = b[13:11];
         e.has_index = b[13:11] != 3'h4;
         e.stack_seg = bs == 3'h4 || (bs == 3'h5 && md != 2'h0);
         e.has_base = !(md == 2'h0 && bs == 3'h5);
         e.disp_size = e.has_base ? e.disp_size : AFD_DISP_32;
      end
      return e;
   endfunction

   function automatic logic refc(input logic [4:0] f, input logic [3:0] t);
      logic c;
      case (t[3:1])
         3'h0: c = f[0];
         3'h1: c = f[1];
         3'h2: c = f[2];
         3'h3: c = f[1] | f[2];
         3'h4: c = f[3];
         3'h5: c = f[4];
         3'h6: c = f[3] ^ f[0];
         default: c = (f[3] ^ f[0]) | f[2];
      endcase
      return c ^ t[0];
   endfunction

   // ====================
   // compares and bus tasks
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // unused register fields cleared on both sides
   task automatic cmp_ea(input afd_ea_s g, input afd_ea_s e);
      if (e.has_base !== 1'b1)
      begin
         g.base_reg = 3'h0;
         e.base_reg = 3'h0;
      end
      if (e.has_index !== 1'b1)
      begin
         g.index_reg = 3'h0;
         e.index_reg = 3'h0;
      end
      if (e.sib_present !== 1'b1)
      begin
         g.scale = 2'h0;
         e.scale = 2'h0;
      end
      cmp_word(32'(g), 32'(e));
   endtask

   task automatic wrs(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      mst.xfer(1'b1, a, d, r, er);
      @(posedge pclk);
      #1;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] r;
      logic er;
      mst.xfer(1'b0, a, 32'h0, r, er);
      cmp_word(r, e);
      cmp_word({31'h0, er}, {31'h0, ee});
   endtask

   task automatic tally_and_finish;
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ====================
   // tests
   initial
   begin
      logic [15:0] bv;
      logic [2:0] ix;
      logic [2:0] rr;
      logic [2:0] gg;
      logic [1:0] ss;
      logic ww;
      logic sv;
      logic pv;
      afd_ea_s x;
      presetn = 1'b0;
      fail_count = 0;
      checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`AFD_OFS_BYTES, `AFD_BYTES_RST, 1'b0);
      rdc(`AFD_OFS_CTL, `AFD_CTL_RST, 1'b0);
      rdc(`AFD_OFS_FLAGS, `AFD_FLAGS_RST, 1'b0);
      rdc(`AFD_OFS_IMM, `AFD_IMM_RST, 1'b0);
      rdc(8'h1c, 32'h0, 1'b1);
      wrs(`AFD_OFS_EA, 32'hffff_ffff);
      rdc(`AFD_OFS_EA, 32'(ref_ea(1'b0, 16'h0)), 1'b0);
      for (int c = 0; c < 4; c++)
      begin
         wrs(`AFD_OFS_CTL, mkc(4'h0, 3'h0, 3'h0, 2'h3, 7'(c)));
         for (int m = 0; m < 3; m++)
            for (int r = 0; r < 8; r++)
               for (int b = 0; b < 8; b++)
               begin
                  ix = 3'(b) ^ 3'h1;
                  ss = (ix == 3'h4) ? 2'h0 : 2'(b);
                  bv = {ss, ix, 3'(b), 2'(m), 3'(7 - r), 3'(r)};
                  wrs(`AFD_OFS_BYTES, {16'h0, bv});
                  cmp_ea(ea, ref_ea(c[0] ^ c[1], bv));
               end
      end
      wrs(`AFD_OFS_CTL, mkc(4'h0, 3'h0, 3'h0, 2'h3, 7'h40));
      x = '0;
      x.implied = 1'b1;
      rdc(`AFD_OFS_EA, 32'(x), 1'b0);
      for (int k = 0; k < 16; k++)
      begin
         rr = 3'(k);
         gg = ~rr;
         ww = k[3];
         wrs(`AFD_OFS_CTL, mkc(4'h0, 3'h0, 3'h0, 2'h3, {3'h0, rr[0], ww, 2'h0}));
         wrs(`AFD_OFS_BYTES, {24'h0, 2'h3, gg, rr});
         cmp_word(32'({ea.reg_operand, o.reg_is_dest, o.rm_high, o.rm_num[1:0], ww & o.rm_num[2],
            o.reg_high, o.reg_num[1:0], o.op_ext}), 32'({1'b1, rr[0], !ww & rr[2], rr[1:0],
            ww & rr[2], !ww & gg[2], gg[1:0], gg}));
      end
      for (int f = 0; f < 32; f++)
      begin
         wrs(`AFD_OFS_FLAGS, 32'(f));
         for (int t = 0; t < 16; t++)
         begin
            wrs(`AFD_OFS_CTL, mkc(4'(t), 3'h0, 3'h0, 2'h3, 7'h00));
            cmp_word({31'h0, o.cond_true}, {31'h0, refc(5'(f), 4'(t))});
         end
      end
      for (int cl = 0; cl < 4; cl++)
         for (int e = 0; e < 8; e++)
         begin
            sv = e <= 5;
            pv = cl == 3 || (cl == 0 && (e == 0 || e == 2 || e == 3)) ||
                 (cl == 1 && e != 4 && e != 5) || (cl == 2 && e >= 6);
            wrs(`AFD_OFS_CTL, mkc(4'h0, 3'(e), 3'(e), 2'(cl), 7'h00));
            cmp_word(32'({o.seg_num, o.seg_valid, o.spec_num, o.spec_valid, o.undefined}),
               32'({3'(e), sv, 3'(e), pv, !(sv && pv)}));
         end
      for (int v = 0; v < 2; v++)
      begin
         bv = v[0] ? 16'h5680 : 16'h007f;
         wrs(`AFD_OFS_IMM, {16'h1234, bv});
         for (int k = 0; k < 8; k++)
         begin
            wrs(`AFD_OFS_CTL, mkc(4'h0, 3'h0, 3'h0, 2'h3, {1'b0, k[2], k[1], 1'b0, k[0], 2'h0}));
            cmp_word(imm, !k[0] ? {24'h0, bv[7:0]} : (k[1] & k[2]) ? {{24{bv[7]}}, bv[7:0]} :
               {16'h1234, bv});
         end
      end
      tally_and_finish;
   end

   initial
   begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      tally_and_finish;
   end
endmodule // afd_decoder_bench
